// [i2c_ee_device.sv]
// EEPROM slave: select decode, write modes, protection and program cycle
`timescale 1ns/1ps
// Behaviour
// RULE1 - Top four select bits must match type
// RULE2 - Next two bits match chip-select pins
// RULE3 - Seventh bit picks 256-byte block
// RULE4 - Eighth bit: one read, zero write
// RULE5 - Acknowledge matching select in ninth bit
// RULE6 - Mode pin high multibyte, low page
// RULE7 - Address byte follows select, acknowledged
// RULE8 - Write-inhibit high leaves array unchanged
// RULE9 - Single byte write independent of mode
// RULE10 - Multibyte: one to four acknowledged bytes
// RULE11 - Multibyte program 10ms, 20ms spanning rows; code doubles on crossing a four-byte boundary (address bits 7:2)
// RULE12 - Over four multibyte bytes may spill
// RULE13 - Page: up to eight bytes, one row
// RULE14 - Page increments only three low bits
// RULE15 - Stop starts program; inputs ignored meanwhile
// RULE16 - Polling select unacknowledged until cycle ends
// RULE17 - Protect boundary to 1FFh when enabled
// RULE18 - Boundary from pointer's upper five bits
// RULE19 - Master writes data, then pointer
// RULE20 - Protect pin low: no protection
// RULE21 - Multibyte from below boundary writes through
// RULE22 - Blocked bytes acknowledged but not programmed
module i2c_ee_device
	import i2c_ee_pkg::*;
#(
	parameter logic [3:0] TYPE_ID = 4'h5, // Arbitrary value
	parameter int PROG_CYC = PROG_CYCLES,
	parameter int PROG_LONG_CYC = PROG_LONG_CYCLES
)
(
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	i2c_link_if.device LINK,
	input wire logic CHIP_SELECT_LOW_PIN_I,
	input wire logic CHIP_SELECT_HIGH_PIN_I,
	input wire logic MODE_I,
	input wire logic WRITE_INHIBIT_PIN_I,
	input wire logic PROTECT_EN_I,
	output logic BUSY_O
);
	localparam int TW = $clog2(PROG_LONG_CYC + 1);

	if (PROG_CYC < 1 || PROG_LONG_CYC < PROG_CYC)
		$error("Program cycle counts out of range");

	typedef enum {D_IDLE, D_SEL, D_ADDR, D_DATA, D_SKIP, D_PROG} dstate_e;

	dstate_e state;
	logic [1:0] scl_s;
	logic [1:0] sda_s;
	logic scl_q;
	logic sda_q;
	logic [4:0] pin_s1;
	logic [4:0] pin_s2;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] sh;
	logic [3:0] bit_cnt;
	logic in_ack;
	logic drive;
	logic block;
	logic [7:0] addr_cnt;
	logic [8:0] start_addr;
	logic mb_cmd;
	logic span;
	logic [3:0] count;
	logic [7:0] valid;
	logic [8:0] slot_addr [ROW_BYTES];
	logic [7:0] slot_data [ROW_BYTES];
	logic [7:0] mem [MEM_BYTES];
	logic [TW-1:0] prog_cnt;
	logic byte_end;
	logic sel_match;
	logic commit;
	logic inhibit;
	logic protect_en;
	logic mode_mb;
	logic [2:0] slot;
	logic [8:0] cur_addr;

	// Both link lines and all strap pins pass two flops before use
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			pin_s1 <= 5'h00;
			pin_s2 <= 5'h00;
		end
		else
		begin
			scl_s <= {scl_s[0], LINK.scl};
			sda_s <= {sda_s[0], LINK.sda};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
			pin_s1 <= {PROTECT_EN_I, WRITE_INHIBIT_PIN_I, MODE_I,
				CHIP_SELECT_HIGH_PIN_I, CHIP_SELECT_LOW_PIN_I};
			pin_s2 <= pin_s1;
		end
	end

	// Bus events seen from the synchronised lines
	assign scl_rise = scl_s[1] & ~scl_q;
	assign scl_fall = ~scl_s[1] & scl_q;
	assign start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1];
	assign stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1];
	assign protect_en = pin_s2[4];
	assign inhibit = pin_s2[3];
	assign mode_mb = pin_s2[2]; // RULE6
	assign byte_end = scl_fall & (bit_cnt == 4'h8) & ~in_ack;
	assign sel_match = (sh[7:4] == TYPE_ID) // RULE1
		&& (sh[3:2] == pin_s2[1:0]); // RULE2
	assign cur_addr = {block, addr_cnt};
	// Page mode stores by low address bits so a ninth byte overwrites the first
	assign slot = mode_mb ? count[2:0] : addr_cnt[2:0]; // RULE14 RULE12
	assign commit = stop_det && (state == D_DATA) && (|valid); // RULE15

	// Protected when pin high, flag clear and at or above the row boundary
	function automatic logic prot(input logic [8:0] a, input logic [7:0] ptr, input logic en);
		prot = en // RULE20
			&& a[8] && !ptr[PROTECT_FLAG_BIT] // RULE17
			&& (a[7:0] >= {ptr[7:3], 3'h0}); // RULE18
	endfunction

	// Bit shifter and acknowledge slot timing
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			sh <= 8'h00;
			bit_cnt <= 4'h0;
			in_ack <= 1'b0;
		end
		else if (state == D_PROG || start_det || stop_det)
		begin
			bit_cnt <= 4'h0;
			in_ack <= 1'b0;
		end
		else if (scl_rise && bit_cnt < 4'h8)
		begin
			sh <= {sh[6:0], sda_s[1]};
			bit_cnt <= bit_cnt + 4'h1;
		end
		else if (byte_end)
			in_ack <= 1'b1;
		else if (scl_fall && in_ack)
		begin
			in_ack <= 1'b0;
			bit_cnt <= 4'h0;
		end
	end

	// Data line pulled low for the whole ninth clock when acknowledging
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			drive <= 1'b0;
		else if (state == D_PROG || start_det || stop_det)
			drive <= 1'b0;
		else if (byte_end)
			drive <= (state == D_SEL) ? sel_match // RULE5 RULE16
				: (state == D_ADDR || state == D_DATA); // RULE7 RULE22
		else if (scl_fall && in_ack)
			drive <= 1'b0;
	end
	assign LINK.sda_d_o = 1'b0;
	assign LINK.sda_d_oe = drive;

	// Transfer sequencing; the program cycle shuts out starts and stops
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			state <= D_IDLE;
		else
		begin
			case (state)
				D_PROG:
					if (prog_cnt == TW'(1))
						state <= D_IDLE; // RULE15
				default:
					if (commit)
						state <= D_PROG; // RULE15
					else if (stop_det)
						state <= D_IDLE;
					else if (start_det)
						state <= D_SEL;
					else if (byte_end)
					begin
						case (state)
							D_SEL:
								state <= !sel_match ? D_SKIP
									: sh[0] ? D_SKIP : D_ADDR; // RULE4
							D_ADDR:
								state <= D_DATA;
							default:
								state <= state;
						endcase
					end
			endcase
		end
	end

	// Address counter and the row latches
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			block <= 1'b0;
			addr_cnt <= 8'h00;
			start_addr <= 9'h000;
			mb_cmd <= 1'b0;
			span <= 1'b0;
			count <= 4'h0;
			valid <= 8'h00;
			for (int i = 0; i < ROW_BYTES; i++)
			begin
				slot_addr[i] <= 9'h000;
				slot_data[i] <= 8'h00;
			end
		end
		else if (byte_end && state == D_SEL && sel_match)
			block <= sh[1]; // RULE3
		else if (byte_end && state == D_ADDR)
		begin
			addr_cnt <= sh; // RULE7
			start_addr <= {block, sh};
			mb_cmd <= mode_mb;
			span <= 1'b0;
			count <= 4'h0;
			valid <= 8'h00;
		end
		else if (byte_end && state == D_DATA)
		begin
			slot_addr[slot] <= cur_addr;
			slot_data[slot] <= sh;
			valid[slot] <= 1'b1;
			if (count != 4'hF)
				count <= count + 4'h1;
			if (cur_addr[7:2] != start_addr[7:2])
				span <= 1'b1; // RULE11
			if (mode_mb)
				addr_cnt <= addr_cnt + 8'h01; // RULE10
			else
				addr_cnt <= {addr_cnt[7:3], addr_cnt[2:0] + 3'h1}; // RULE14 RULE13
		end
	end

	// Self-timed cycle, doubled when a multibyte write crossed a four-byte boundary (address bits 7:2)
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			prog_cnt <= '0;
		else if (commit)
			prog_cnt <= (mb_cmd && span) ? TW'(PROG_LONG_CYC) : TW'(PROG_CYC); // RULE11
		else if (prog_cnt != '0)
			prog_cnt <= prog_cnt - TW'(1);
	end
	assign BUSY_O = (state == D_PROG);

	// Array update at stop; multibyte judges protection from its first byte only
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			for (int i = 0; i < MEM_BYTES; i++)
				mem[i] <= ERASED_BYTE;
		end
		else if (commit && !inhibit) // RULE8 RULE9
		begin
			for (int i = 0; i < ROW_BYTES; i++)
				if (valid[i] && !(mb_cmd ? prot(start_addr, mem[PTR_LOC], protect_en) // RULE21
					: prot(slot_addr[i], mem[PTR_LOC], protect_en))) // RULE22
					mem[slot_addr[i]] <= slot_data[i];
		end
	end
endmodule

// [i2c_ee_pkg.sv]
// Shared constants for the serial EEPROM write path and its bus master
package i2c_ee_pkg;
	// Clock and program timing
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_MS = 10;
	localparam int PROG_LONG_TIME_MS = 20;
	localparam int PROG_CYCLES = PROG_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int PROG_LONG_CYCLES = PROG_LONG_TIME_MS * (CLK_FREQ_HZ / 1000);
	// Serial clock made by the master, 100 kHz
	localparam int SCL_PERIOD_NS = 10_000;
	localparam int SCL_QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// Array geometry
	localparam int MEM_BYTES = 512;
	localparam int ROW_BYTES = 8;
	localparam logic [8:0] PTR_LOC = 9'h1FF;
	localparam int PROTECT_FLAG_BIT = 2;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// Master register map and fields
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_SEL = 4'h1;
	localparam logic [3:0] REG_ADDR = 4'h2;
	localparam logic [3:0] REG_STATUS = 4'h3;
	localparam logic [3:0] REG_DATA0 = 4'h8;
	localparam int STAT_BUSY = 0;
	localparam int STAT_NACK = 1;
endpackage

// [i2c_link_if.sv]
// Two-wire link between bus master and EEPROM, open-drain data line
`timescale 1ns/1ps
interface i2c_link_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic sda;
	// Pulled-up wire: low whenever any enabled driver drives low
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));
	modport master(output scl, output sda_m_o, output sda_m_oe, input sda);
	modport device(input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// [i2c_ee_master.sv]
// Bus master: sends select, address and data bytes on command
`timescale 1ns/1ps
module i2c_ee_master
	import i2c_ee_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	i2c_link_if.master LINK,
	input wire logic [3:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O
);
	localparam int QW = $clog2(SCL_QUARTER_CYCLES + 1);

	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} hstate_e;

	hstate_e state;
	logic [7:0] sel;
	logic [7:0] addr;
	logic [7:0] data [ROW_BYTES];
	logic [3:0] nbytes;
	logic busy;
	logic nack;
	logic [QW-1:0] qcnt;
	logic tick;
	logic [1:0] phase;
	logic [3:0] bit_idx;
	logic [4:0] byte_idx;
	logic [7:0] cur;
	logic last;
	logic [1:0] sda_s;
	logic scl;
	logic low;
	logic next_scl;
	logic next_low;

	// Software writes; a command while busy is dropped
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			sel <= 8'h00;
			addr <= 8'h00;
			nbytes <= 4'h0;
			for (int i = 0; i < ROW_BYTES; i++)
				data[i] <= 8'h00;
		end
		else if (WR_I)
		begin
			if (ADDR_I == REG_SEL)
				sel <= WDATA_I;
			else if (ADDR_I == REG_ADDR)
				addr <= WDATA_I;
			else if (ADDR_I == REG_CMD && !busy)
				nbytes <= WDATA_I[3:0];
			else if (ADDR_I >= REG_DATA0)
				data[ADDR_I[2:0]] <= WDATA_I;
		end
	end

	// Read data one cycle after the strobe; unmapped reads as zero
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			RDATA_O <= 8'h00;
		else if (RD_I)
		begin
			case (ADDR_I)
				REG_CMD: RDATA_O <= {4'h0, nbytes};
				REG_SEL: RDATA_O <= sel;
				REG_ADDR: RDATA_O <= addr;
				REG_STATUS: RDATA_O <= 8'(({7'h00, nack} << STAT_NACK) | (8'(busy) << STAT_BUSY));
				default: RDATA_O <= (ADDR_I >= REG_DATA0) ? data[ADDR_I[2:0]] : 8'h00;
			endcase
		end
	end

	// Quarter-period divider for the serial clock
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			qcnt <= '0;
		else if (!busy || tick)
			qcnt <= '0;
		else
			qcnt <= qcnt + QW'(1);
	end
	assign tick = busy && (qcnt == QW'(SCL_QUARTER_CYCLES - 1));

	// Data line sampled through two flops; only the acknowledge uses it
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			sda_s <= 2'h3;
		else
			sda_s <= {sda_s[0], LINK.sda};
	end

	// Byte being sent: select, address, then data slots wrapping after eight
	assign cur = (byte_idx == 5'h00) ? sel
		: (byte_idx == 5'h01) ? addr : data[3'(byte_idx - 5'h02)];
	assign last = (nbytes == 4'h0) ? (byte_idx == 5'h00) : (byte_idx == 5'(nbytes) + 5'h01);

	// Frame sequencer: start, nine-clock bytes, stop
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			state <= H_IDLE;
			busy <= 1'b0;
			nack <= 1'b0;
			phase <= 2'h0;
			bit_idx <= 4'h0;
			byte_idx <= 5'h00;
		end
		else if (state == H_IDLE)
		begin
			if (WR_I && ADDR_I == REG_CMD)
			begin
				state <= H_START;
				busy <= 1'b1;
				nack <= 1'b0;
				phase <= 2'h0;
				bit_idx <= 4'h0;
				byte_idx <= 5'h00;
			end
		end
		else if (tick)
		begin
			phase <= phase + 2'h1;
			if (state == H_BIT && phase == 2'h2 && bit_idx == 4'h8)
				nack <= sda_s[1];
			if (phase == 2'h3)
			begin
				case (state)
					H_START:
						state <= H_BIT;
					H_BIT:
						if (bit_idx != 4'h8)
							bit_idx <= bit_idx + 4'h1;
						else
						begin
							bit_idx <= 4'h0;
							byte_idx <= byte_idx + 5'h01;
							if (nack || last)
								state <= H_STOP;
						end
					default:
					begin
						state <= H_IDLE;
						busy <= 1'b0;
					end
				endcase
			end
		end
	end

	// Pin levels per phase
	always_comb
	begin
		next_scl = 1'b1;
		next_low = 1'b0;
		case (state)
			H_START:
			begin
				next_scl = (phase != 2'h3);
				next_low = (phase != 2'h0);
			end
			H_BIT:
			begin
				next_scl = (phase == 2'h1) || (phase == 2'h2);
				next_low = (bit_idx != 4'h8) && !cur[3'(4'h7 - bit_idx)];
			end
			H_STOP:
			begin
				next_scl = (phase != 2'h0);
				next_low = (phase < 2'h2);
			end
			default:
			begin
				next_scl = 1'b1;
				next_low = 1'b0;
			end
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			scl <= 1'b1;
			low <= 1'b0;
		end
		else
		begin
			scl <= next_scl;
			low <= next_low;
		end
	end
	assign LINK.scl = scl;
	assign LINK.sda_m_o = 1'b0;
	assign LINK.sda_m_oe = low;
endmodule

// [i2c_ee_sva.sv]
// Link and program-cycle assertions for the EEPROM write path
`timescale 1ns/1ps
module i2c_ee_sva
#(
	parameter int PROG_LONG_CYC = 200000
)
(
	input wire logic MCLK_I,
	input wire logic RST_B_I,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_o,
	input wire logic sda_m_oe,
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	input wire logic BUSY_O
);
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_cnt;
	int busy_cnt;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RST_B_I);
	// Clock rises since START, wrapping after the ninth bit
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bit_cnt <= 4'h0;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda)
				bit_cnt <= 4'h0;
			else if (scl && !scl_q)
				bit_cnt <= (bit_cnt == 4'h9) ? 4'h1 : bit_cnt + 4'h1;
		end
	end
	// Length of the current program cycle
	always_ff @(posedge MCLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			busy_cnt <= 0;
		else
			busy_cnt <= BUSY_O ? busy_cnt + 1 : 0;
	end
	dev_pull_low_a: assert property (sda_d_oe |-> !sda_d_o)
		else $error("device drives the data line high");
	ack_ninth_a: assert property ($rose(sda_d_oe) |-> bit_cnt == 4'h8)
		else $error("acknowledge outside the ninth bit");
	ack_scl_low_a: assert property ($changed(sda_d_oe) |-> !scl)
		else $error("acknowledge changed while clock high");
	ack_hold_a: assert property ($rose(sda_d_oe) |-> sda_d_oe [*8])
		else $error("acknowledge dropped early");
	ack_release_a: assert property ($rose(sda_d_oe) |-> ##[1:150] $fell(sda_d_oe))
		else $error("acknowledge not released");
	busy_quiet_a: assert property (BUSY_O |-> !sda_d_oe)
		else $error("device answered while programming");
	busy_start_a: assert property ($rose(BUSY_O) |-> scl && sda && $past(scl, 4))
		else $error("program cycle began without stop");
	busy_len_a: assert property (BUSY_O |-> busy_cnt < PROG_LONG_CYC)
		else $error("program cycle too long");
	master_low_a: assert property (sda_m_oe |-> !sda_m_o)
		else $error("master drives the data line high");
	cover property ($rose(sda_d_oe));
	cover property (scl && $fell(sda));
	cover property (BUSY_O && busy_cnt == PROG_LONG_CYC - 1);
endmodule

// [i2c_eeprom_write_protect_tb.sv]
// Self-checking bench: master and EEPROM joined over the two-wire link
`timescale 1ns/1ps
module i2c_eeprom_write_protect_tb;
	import i2c_ee_pkg::*;
	localparam int P_SHORT = 1500;
	localparam int P_LONG = 3000;
	localparam logic [3:0] TID = 4'h5; // Arbitrary type value
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic cs_lo = 1'b0;
	logic cs_hi = 1'b0;
	logic mode = 1'b0;
	logic wi = 1'b0;
	logic pe = 1'b0;
	logic busy;
	logic chk_rd = 1'b0;
	logic chk_d = 1'b0;
	logic [7:0] sq[$];
	logic [7:0] dv [8];
	logic [7:0] img [MEM_BYTES];
	int bq[$];
	int bcnt = 0;
	int eb;
	int fails = 0;
	int cmp_count = 0;
	logic [7:0] d;
	logic [1:0] cs;
	int i;
	i2c_link_if link();
	i2c_ee_master i2c_ee_master_i (.MCLK_I(mclk), .RST_B_I(rst_b), .LINK(link), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
	i2c_ee_device #(.TYPE_ID(TID), .PROG_CYC(P_SHORT), .PROG_LONG_CYC(P_LONG)) i2c_ee_device_i (
		.MCLK_I(mclk), .RST_B_I(rst_b), .LINK(link), .CHIP_SELECT_LOW_PIN_I(cs_lo),
		.CHIP_SELECT_HIGH_PIN_I(cs_hi), .MODE_I(mode), .WRITE_INHIBIT_PIN_I(wi),
		.PROTECT_EN_I(pe), .BUSY_O(busy));
	i2c_ee_sva #(.PROG_LONG_CYC(P_LONG)) i2c_ee_sva_i (.MCLK_I(mclk), .RST_B_I(rst_b),
		.scl(link.scl), .sda(link.sda), .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
		.sda_d_o(link.sda_d_o), .sda_d_oe(link.sda_d_oe), .BUSY_O(busy));
	// Clock and reset
	initial
		forever #50 mclk = ~mclk;
	initial
	begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic timeout();
		fails++;
		complete_run();
	endtask
	// Monitor: queued status and address reads and program-cycle lengths, oldest first
	always @(posedge mclk)
	begin
		if (chk_d)
			check("rdata", {24'h0, rdata}, {24'h0, sq.pop_front()});
		chk_d <= rd & chk_rd;
		if (busy === 1'b1)
			bcnt <= bcnt + 1;
		else if (bcnt != 0)
		begin
			eb = (bq.size() != 0) ? bq.pop_front() : 0;
			check("busy_len", bcnt, eb);
			bcnt <= 0;
		end
	end
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic c, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		chk_rd <= c;
		if (c)
			sq.push_back(e);
		@(posedge mclk);
		rd <= 1'b0;
		chk_rd <= 1'b0;
		@(posedge mclk);
		#1 d = rdata;
	endtask
	// One frame: select, address, n data bytes (select alone when n is 0); blen 0 means no program cycle
	task automatic run(input logic [7:0] sel, input logic [7:0] a, input int n,
		input logic nack, input int blen);
		int k;
		logic [8:0] ev [8];
		logic [8:0] pa;
		if (blen > 0)
			bq.push_back(blen);
		wr_reg(REG_SEL, sel);
		wr_reg(REG_ADDR, a);
		for (k = 0; k < n; k++)
		begin
			// Page addresses wrap inside the row, multibyte ones run on
			ev[k] = mode ? {sel[1], a + 8'(k)} : {sel[1], a[7:3], a[2:0] + 3'(k)};
			// Pointer writes carry a known boundary with the flag clear
			dv[k] = (ev[k] == PTR_LOC) ? 8'hF0 : 8'($urandom);
			wr_reg(REG_DATA0 + k[3:0], dv[k]);
		end
		wr_reg(REG_CMD, 8'(n));
		d = 8'h01;
		for (k = 0; d[STAT_BUSY] !== 1'b0; k++)
		begin
			if (k > 5000)
				timeout();
			rd_reg(REG_STATUS, 1'b0, 8'h00);
		end
		rd_reg(REG_STATUS, 1'b1, {6'h00, nack, 1'b0});
		rd_reg(REG_ADDR, 1'b1, a);
		// Expected array; multibyte protection is judged at its first byte only
		for (k = 0; k < n && !nack && !wi; k++)
		begin
			pa = mode ? {sel[1], a} : ev[k];
			if (!(pe && pa[8] && !img[PTR_LOC][PROTECT_FLAG_BIT]
				&& pa[7:0] >= {img[PTR_LOC][7:3], 3'h0}))
				img[ev[k]] = dv[k];
		end
	endtask
	// Whole array against the bench's own image of every write
	task automatic mem_chk();
		int j;
		for (j = 0; j < MEM_BYTES; j++)
			check("mem", {24'h0, i2c_ee_device_i.mem[j]}, {24'h0, img[j]});
	endtask
	// Bounded wait for the program cycle to end
	task automatic wait_free();
		int k;
		for (k = 0; busy !== 1'b0; k++)
		begin
			if (k > 4000)
				timeout();
			@(posedge mclk);
		end
		@(posedge mclk);
		mem_chk();
	endtask
	initial
	begin
		void'($urandom(32'h1C52));
		for (i = 0; i < MEM_BYTES; i++)
			img[i] = ERASED_BYTE;
		cs = 2'($urandom);
		cs_lo <= cs[0];
		cs_hi <= cs[1];
		mode <= 1'($urandom);
		repeat (10) @(posedge mclk);
		// Byte write, then polling while busy and after
		run({TID, cs, 1'($urandom), 1'b0}, 8'($urandom), 1, 1'b0, P_SHORT);
		run({TID, cs, 2'b00}, 8'h00, 0, 1'b1, 0);
		wait_free();
		run({TID, cs, 2'b00}, 8'h00, 0, 1'b0, 0);
		// Foreign type or chip select gets no answer; a read select is acknowledged
		run({TID ^ 4'h3, cs, 2'b00}, 8'h10, 1, 1'b1, 0);
		for (i = 1; i < 4; i++)
			run({TID, cs ^ 2'(i), 2'b00}, 8'h10, 1, 1'b1, 0);
		run({TID, cs, 2'b01}, 8'h00, 0, 1'b0, 0);
		// Multibyte: crossing a row doubles the cycle
		mode <= 1'b1;
		run({TID, cs, 2'b10}, 8'h06, 4, 1'b0, P_LONG);
		wait_free();
		run({TID, cs, 2'b00}, 8'h04, 4, 1'b0, P_SHORT);
		wait_free();
		// Page mode stays in one row
		mode <= 1'b0;
		run({TID, cs, 2'b10}, 8'h05, 8, 1'b0, P_SHORT);
		wait_free();
		// Inhibited write to the pointer still acknowledged
		wi <= 1'b1;
		pe <= 1'b1;
		run({TID, cs, 2'b10}, 8'hFF, 1, 1'b0, P_SHORT);
		wait_free();
		// Protection: data first, then the pointer while the pin is low
		wi <= 1'b0;
		pe <= 1'b0;
		run({TID, cs, 2'b10}, 8'hF0, 2, 1'b0, P_SHORT);
		wait_free();
		run({TID, cs, 2'b10}, 8'hFF, 1, 1'b0, P_SHORT);
		wait_free();
		// Pin high: page bytes in the region are dropped, still acknowledged
		pe <= 1'b1;
		run({TID, cs, 2'b10}, 8'hF0, 2, 1'b0, P_SHORT);
		wait_free();
		// Multibyte just below the boundary spills into it across two rows
		mode <= 1'b1;
		run({TID, cs, 2'b10}, 8'hEF, 4, 1'b0, P_LONG);
		wait_free();
		complete_run();
	end
endmodule
